/* File: osdp_device.sv */
// Display device: raster and area planes, line counter interrupt, display memory port.
// Contract
// (R1) Raster blank bit colours whole page background.
// (R2) Luma/blank select drives blank on shared output.
// (R3) Raster colour field indexes palette zero to seven.
// (R4) Two area planes; plane one wins overlap.
// (R5) Each plane has own enable bit.
// (R6) Plane colours from fields two-zero and six-four.
// (R7) Intensity only in planes; shared pin when enabled.
// (R8) Intensity per plane select, follows plane priority.
// (R9) Four-bit line counter: vsync clears, hsync increments.
// (R10) Software reads line counter repeatedly for stability.
// (R11) Line counter reads in interrupt register low bits.
// (R12) Source bit picks vsync or line-match interrupt.
// (R13) Line value zero means interrupt on counter clear.
// (R14) Software writes address high bit before low byte.
// (R15) Register writes take effect at once.
// (R16) Software leaves two cycles between memory accesses.
// (R17) Software uses only single-byte accesses.
// (R18) Software should write undisplayed locations only.
// (R19) Plain mode: code low and ornament writes increment.
// (R20) Bank write: ornament held, code low stores both.
// (R21) Single read: code low or ornament read increments.
// (R22) Bank read: increment only after code low read.
// (R23) Read-modify-write: reads keep address, writes increment.
// (R24) All colour indices share one external palette.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module osdp_device (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	osdp_if.dev             bus,
	input  wire logic       vsync_n,
	input  wire logic       hsync_n,
	input  wire logic       row_last_line,
	input  wire logic       in_plane_one,
	input  wire logic       in_plane_two,
	input  wire logic       char_luma,
	input  wire logic [8:0] disp_addr,
	output logic [15:0]     disp_word,
	output logic [2:0]      colour_index,
	output logic            raster_active,
	output logic            plane_active,
	output logic            luma_blank_output,
	output logic            shared_port_pin,
	output logic [3:0]      display_line_count,
	output logic            irq
);
	typedef struct packed {
		logic [7:0]  raster;
		logic [7:0]  area;
		logic [4:0]  irqc;
		logic [7:0]  pinf;
		logic [2:0]  misc;
		logic [8:0]  addr;
		logic        code_hi;
		logic [6:0]  orn_hold;
		logic        vs_m;
		logic        vs_s;
		logic        vs_d;
		logic        hs_m;
		logic        hs_s;
		logic        hs_d;
		logic [3:0]  cnt;
		logic        irq;
		logic        ack;
		logic [7:0]  rdata;
		logic [2:0]  col;
		logic        ras_act;
		logic        pl_act;
		logic        lb_out;
		logic        port_pin;
	} osdp_dev_s;

	osdp_dev_s  s_r;
	osdp_dev_s  s_nxt;
	logic [15:0] mem [0:(1 << osdp_pkg::ADDR_W) - 1];
	logic [15:0] cur_word;
	logic        mem_we;
	logic [15:0] mem_wdata;
	logic        vs_fall;
	logic        hs_fall;
	logic        line_end;
	logic        take;
	logic        dir_rd;
	logic        bank;
	logic        rmw;
	logic        p1_vis;
	logic        p2_vis;
	logic [3:0]  line_val;

	assign cur_word = mem[s_r.addr];

	// Next state: synchronisers, line counter, interrupt, register port and planes.
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.irq = 1'b0;
		mem_we = 1'b0;
		mem_wdata = cur_word;
		s_nxt.vs_m = vsync_n;
		s_nxt.vs_s = s_r.vs_m;
		s_nxt.vs_d = s_r.vs_s;
		s_nxt.hs_m = hsync_n;
		s_nxt.hs_s = s_r.hs_m;
		s_nxt.hs_d = s_r.hs_s;
		vs_fall = s_r.vs_d & ~s_r.vs_s;
		hs_fall = s_r.hs_d & ~s_r.hs_s;
		line_end = hs_fall & row_last_line;
		line_val = s_r.irqc[3:0];
		dir_rd = s_r.misc[osdp_pkg::MISC_DIR_BIT];
		bank = s_r.misc[osdp_pkg::MISC_BANK_BIT];
		rmw = s_r.misc[osdp_pkg::MISC_RMW_BIT];
		// Vertical sync clears, end of a display line's last scan counts up.
		if (vs_fall) begin
			s_nxt.cnt = 4'h0; // [R9]
		end else if (line_end) begin
			s_nxt.cnt = s_r.cnt + 4'h1; // [R9]
		end
		// Interrupt pulse from vsync or from a counter match.
		if (s_r.irqc[osdp_pkg::IRQ_SRC_BIT]) begin
			s_nxt.irq = vs_fall; // [R12]
		end else if (line_val == 4'h0) begin
			s_nxt.irq = vs_fall; // [R13]
		end else begin
			s_nxt.irq = line_end & ~vs_fall & ((s_r.cnt + 4'h1) == line_val); // [R12] [R13]
		end
		// One access is taken per request; the answer pulse blocks a repeat.
		take = bus.req & ~s_r.ack;
		if (take) begin
			s_nxt.ack = 1'b1;
			s_nxt.rdata = 8'h00;
			if (bus.we) begin
				// Written values steer the planes from the next cycle on.
				case (bus.idx)
					osdp_pkg::REG_RASTER:  s_nxt.raster = bus.wdata; // [R15]
					osdp_pkg::REG_AREA:    s_nxt.area = bus.wdata; // [R15]
					osdp_pkg::REG_IRQ:     s_nxt.irqc = bus.wdata[4:0]; // [R15]
					osdp_pkg::REG_PINF:    s_nxt.pinf = bus.wdata; // [R15]
					osdp_pkg::REG_MISC:    s_nxt.misc = bus.wdata[2:0];
					osdp_pkg::REG_ADDR_HI: s_nxt.addr[8] = bus.wdata[0];
					osdp_pkg::REG_ADDR_LO: s_nxt.addr[7:0] = bus.wdata;
					osdp_pkg::REG_CODE_HI: s_nxt.code_hi = bus.wdata[0];
					osdp_pkg::REG_CODE_LO: begin
						if (!dir_rd) begin
							mem_we = 1'b1; // [R19]
							mem_wdata = {(bank ? s_r.orn_hold : cur_word[15:9]),
								s_r.code_hi, bus.wdata}; // [R20]
							s_nxt.addr = s_r.addr + 9'h001; // [R19] [R23]
						end
					end
					osdp_pkg::REG_ORN: begin
						if (!dir_rd && bank) begin
							s_nxt.orn_hold = bus.wdata[6:0]; // [R20]
						end else if (!dir_rd) begin
							mem_we = 1'b1;
							mem_wdata = {bus.wdata[6:0], cur_word[8:0]};
							s_nxt.addr = s_r.addr + 9'h001; // [R19] [R23]
						end
					end
					default: s_nxt.ack = 1'b1;
				endcase
			end else begin
				// Reads show state; data reads may advance the address.
				case (bus.idx)
					osdp_pkg::REG_RASTER:  s_nxt.rdata = s_r.raster;
					osdp_pkg::REG_AREA:    s_nxt.rdata = s_r.area;
					osdp_pkg::REG_IRQ:     s_nxt.rdata = {3'h0, s_r.irqc[4], s_r.cnt}; // [R11]
					osdp_pkg::REG_PINF:    s_nxt.rdata = s_r.pinf;
					osdp_pkg::REG_MISC:    s_nxt.rdata = {5'h00, s_r.misc};
					osdp_pkg::REG_ADDR_HI: s_nxt.rdata = {7'h00, s_r.addr[8]};
					osdp_pkg::REG_ADDR_LO: s_nxt.rdata = s_r.addr[7:0];
					osdp_pkg::REG_CODE_HI: s_nxt.rdata = {7'h00, cur_word[8]};
					osdp_pkg::REG_CODE_LO: begin
						s_nxt.rdata = cur_word[7:0];
						if (dir_rd && !rmw) begin
							s_nxt.addr = s_r.addr + 9'h001; // [R21] [R22] [R23]
						end
					end
					osdp_pkg::REG_ORN: begin
						s_nxt.rdata = {1'b0, cur_word[15:9]};
						if (dir_rd && !rmw && !bank) begin
							s_nxt.addr = s_r.addr + 9'h001; // [R21] [R22] [R23]
						end
					end
					default: s_nxt.rdata = 8'h00;
				endcase
			end
		end
		// Plane one over plane two over raster; indices go to the shared palette.
		p1_vis = in_plane_one & s_r.raster[osdp_pkg::RAS_P1_ON_BIT]; // [R5]
		p2_vis = in_plane_two & s_r.raster[osdp_pkg::RAS_P2_ON_BIT]; // [R5]
		s_nxt.ras_act = s_r.raster[osdp_pkg::RAS_BLANK_BIT]; // [R1]
		s_nxt.pl_act = p1_vis | p2_vis; // [R4]
		if (p1_vis) begin
			s_nxt.col = s_r.area[osdp_pkg::AREA_P1_COL +: 3]; // [R4] [R6] [R24]
			s_nxt.port_pin = s_r.area[osdp_pkg::AREA_P1_INT]; // [R8]
		end else if (p2_vis) begin
			s_nxt.col = s_r.area[osdp_pkg::AREA_P2_COL +: 3]; // [R6] [R24]
			s_nxt.port_pin = s_r.area[osdp_pkg::AREA_P2_INT]; // [R8]
		end else begin
			s_nxt.col = s_r.raster[osdp_pkg::RAS_COL_LSB +: 3]; // [R3] [R24]
			s_nxt.port_pin = 1'b0; // [R7]
		end
		// The shared pin carries intensity only when not disabled.
		if (s_r.pinf[osdp_pkg::PINF_IDIS_BIT]) begin
			s_nxt.port_pin = 1'b0; // [R7]
		end
		// With blank select on, blank output is raster or plane or character luma; with it off, character luma only.
		if (s_r.pinf[osdp_pkg::PINF_LB_BIT]) begin
			s_nxt.lb_out = s_nxt.ras_act | s_nxt.pl_act | char_luma; // [R2]
		end else begin
			s_nxt.lb_out = char_luma;
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Display memory: CPU write port and registered display read port.
	always_ff @(posedge aclk) begin
		if (mem_we) begin
			mem[s_r.addr] <= mem_wdata;
		end
		disp_word <= mem[disp_addr];
	end

	assign bus.ack = s_r.ack;
	assign bus.rdata = s_r.rdata;
	assign colour_index = s_r.col;
	assign raster_active = s_r.ras_act;
	assign plane_active = s_r.pl_act;
	assign luma_blank_output = s_r.lb_out;
	assign shared_port_pin = s_r.port_pin;
	assign display_line_count = s_r.cnt;
	assign irq = s_r.irq;
endmodule : osdp_device

/* File: osdp_pkg.sv */
// Shared constants and types for the display plane, line interrupt and memory port.
package osdp_pkg;
	// Register index on the device register port.
	localparam logic [3:0] REG_RASTER  = 4'h0;
	localparam logic [3:0] REG_AREA    = 4'h1;
	localparam logic [3:0] REG_IRQ     = 4'h2;
	localparam logic [3:0] REG_PINF    = 4'h3;
	localparam logic [3:0] REG_ADDR_HI = 4'h4;
	localparam logic [3:0] REG_ADDR_LO = 4'h5;
	localparam logic [3:0] REG_CODE_HI = 4'h6;
	localparam logic [3:0] REG_CODE_LO = 4'h7;
	localparam logic [3:0] REG_ORN     = 4'h8;
	localparam logic [3:0] REG_MISC    = 4'h9;
	// Field positions.
	localparam int RAS_BLANK_BIT  = 6;
	localparam int RAS_P2_ON_BIT  = 5;
	localparam int RAS_P1_ON_BIT  = 4;
	localparam int RAS_COL_LSB    = 0;
	localparam int AREA_P1_COL    = 0;
	localparam int AREA_P1_INT    = 3;
	localparam int AREA_P2_COL    = 4;
	localparam int AREA_P2_INT    = 7;
	localparam int PINF_LB_BIT    = 2;
	localparam int PINF_IDIS_BIT  = 3;
	localparam int IRQ_SRC_BIT    = 4;
	localparam int MISC_DIR_BIT   = 0;
	localparam int MISC_BANK_BIT  = 1;
	localparam int MISC_RMW_BIT   = 2;
	localparam int CODE_W         = 9;
	localparam int ORN_W          = 7;
	localparam int ADDR_W         = 9;
	// Reset values of the control registers.
	localparam logic [7:0] RST_CTRL = 8'h00;
	// Host software register byte addresses and fields.
	localparam logic [3:0] HOST_CMD    = 4'h0;
	localparam logic [3:0] HOST_STATUS = 4'h4;
	localparam int CMD_REG_LSB    = 9;
	localparam int CMD_READ_BIT   = 13;
	localparam int CMD_SETA_BIT   = 14;
	localparam int CMD_STABLE_BIT = 15;
	// Least gap between two device accesses, in clock cycles.
	localparam int GAP_CYCLES = 2;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {H_IDLE, H_REQ, H_GAP} osdp_hstate_e;
endpackage : osdp_pkg

/* File: osdp_if.sv */
// Register port joining the CPU-side controller and the display device.
`timescale 1ns/1ps
interface osdp_if;
	logic       req;
	logic       we;
	logic [3:0] idx;
	logic [7:0] wdata;
	logic       ack;
	logic [7:0] rdata;
	modport dev (input req, input we, input idx, input wdata, output ack, output rdata);
	modport cpu (output req, output we, output idx, output wdata, input ack, input rdata);
endinterface : osdp_if

/* File: osdp_cpu.sv */
// CPU-side controller: AXI4-Lite command registers driving the device register port.
`timescale 1ns/1ps
module osdp_cpu (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	osdp_if.cpu              port
);
	typedef struct packed {
		logic                  awready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
		osdp_pkg::osdp_hstate_e st;
		logic [15:0]           cmd;
		logic                  lo_pending;
		logic                  have_prev;
		logic [1:0]            gap;
		logic [7:0]            last;
		logic                  busy;
		logic                  req;
		logic                  we;
		logic [3:0]            idx;
		logic [7:0]            wdata;
	} osdp_cpu_s;

	osdp_cpu_s s_r;
	osdp_cpu_s s_nxt;
	logic      cmd_go;

	// Next state: AXI4-Lite slave and the access sequencer.
	always_comb begin
		s_nxt = s_r;
		cmd_go = 1'b0;
		// Write address and data are taken together, then answered.
		if (s_r.awready) begin
			s_nxt.awready = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = osdp_pkg::RESP_SLVERR;
			if (s_axi_awaddr == osdp_pkg::HOST_CMD) begin
				s_nxt.bresp = osdp_pkg::RESP_OKAY;
				cmd_go = ~s_r.busy & (&s_axi_wstrb[1:0]);
			end else if (s_axi_awaddr == osdp_pkg::HOST_STATUS) begin
				s_nxt.bresp = osdp_pkg::RESP_OKAY;
			end
		end else if (s_axi_awvalid && s_axi_wvalid && !s_r.bvalid) begin
			s_nxt.awready = 1'b1;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		// Read address taken, data returned the next cycle.
		if (s_r.arready) begin
			s_nxt.arready = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = osdp_pkg::RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			if (s_axi_araddr == osdp_pkg::HOST_CMD) begin
				s_nxt.rdata = {16'h0000, s_r.cmd};
			end else if (s_axi_araddr == osdp_pkg::HOST_STATUS) begin
				s_nxt.rdata = {16'h0000, s_r.last, 7'h00, s_r.busy};
			end else begin
				s_nxt.rresp = osdp_pkg::RESP_SLVERR;
			end
		end else if (s_axi_arvalid && !s_r.rvalid) begin
			s_nxt.arready = 1'b1;
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		// Sequencer: one byte access at a time, then a gap.
		case (s_r.st)
			osdp_pkg::H_IDLE: begin
				if (cmd_go) begin
					s_nxt.cmd = s_axi_wdata[15:0];
					s_nxt.busy = 1'b1;
					s_nxt.req = 1'b1;
					s_nxt.have_prev = 1'b0;
					s_nxt.st = osdp_pkg::H_REQ;
					s_nxt.lo_pending = 1'b0;
					if (s_axi_wdata[osdp_pkg::CMD_SETA_BIT]) begin
						s_nxt.idx = osdp_pkg::REG_ADDR_HI; // [R14]
						s_nxt.wdata = {7'h00, s_axi_wdata[8]}; // [R14]
						s_nxt.we = 1'b1;
						s_nxt.lo_pending = 1'b1;
					end else if (s_axi_wdata[osdp_pkg::CMD_STABLE_BIT]) begin
						s_nxt.idx = osdp_pkg::REG_IRQ; // [R10]
						s_nxt.we = 1'b0;
					end else begin
						s_nxt.idx = s_axi_wdata[osdp_pkg::CMD_REG_LSB +: 4]; // [R17]
						s_nxt.wdata = s_axi_wdata[7:0]; // [R17]
						s_nxt.we = ~s_axi_wdata[osdp_pkg::CMD_READ_BIT];
					end
				end
			end
			osdp_pkg::H_REQ: begin
				if (port.ack) begin
					s_nxt.req = 1'b0;
					s_nxt.last = port.rdata;
					s_nxt.gap = 2'(osdp_pkg::GAP_CYCLES - 1); // [R16]
					s_nxt.st = osdp_pkg::H_GAP;
				end
			end
			osdp_pkg::H_GAP: begin
				if (s_r.gap != 2'd0) begin
					s_nxt.gap = s_r.gap - 2'd1; // [R16]
				end else if (s_r.lo_pending) begin
					s_nxt.lo_pending = 1'b0;
					s_nxt.idx = osdp_pkg::REG_ADDR_LO; // [R14]
					s_nxt.wdata = s_r.cmd[7:0];
					s_nxt.req = 1'b1;
					s_nxt.st = osdp_pkg::H_REQ;
				end else if (s_r.cmd[osdp_pkg::CMD_STABLE_BIT] && s_r.cmd[osdp_pkg::CMD_SETA_BIT] == 1'b0
					&& (!s_r.have_prev || s_r.wdata != s_r.last)) begin
					s_nxt.have_prev = 1'b1;
					s_nxt.wdata = s_r.last; // [R10]
					s_nxt.req = 1'b1;
					s_nxt.st = osdp_pkg::H_REQ;
				end else begin
					s_nxt.busy = 1'b0;
					s_nxt.st = osdp_pkg::H_IDLE;
				end
			end
			default: s_nxt.st = osdp_pkg::H_IDLE;
		endcase
	end

	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.awready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = s_r.rdata;
	assign port.req = s_r.req;
	assign port.we = s_r.we;
	assign port.idx = s_r.idx;
	assign port.wdata = s_r.wdata;
endmodule : osdp_cpu

/* File: osdp_port_props.sv */
// Assertions on the register port joining the controller and the display device.
`timescale 1ns/1ps
module osdp_port_props (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       req,
	input wire logic       we,
	input wire logic [3:0] idx,
	input wire logic [7:0] wdata,
	input wire logic       ack,
	input wire logic [7:0] rdata
);
	logic hi_seen_r;
	logic hi_seen_nxt;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// A request is taken at an edge where it is up and no answer stands.
	sequence s_take;
		req && !ack;
	endsequence
	// The answer closes a transfer and the request falls right behind it.
	sequence s_close;
		ack ##1 !req;
	endsequence
	// Remembers that the high address bit went out, so the low byte is owed next.
	always_comb begin
		hi_seen_nxt = hi_seen_r;
		if (req && !ack) begin
			hi_seen_nxt = we && (idx == osdp_pkg::REG_ADDR_HI);
		end
	end
	// Registers the pending flag.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_seen_r <= 1'b0;
		end else begin
			hi_seen_r <= hi_seen_nxt;
		end
	end
	a_ack_next: assert property (s_take |=> ack)
		else $error("answer did not come one cycle after the request");
	a_ack_single: assert property (ack |=> !ack)
		else $error("answer stood longer than one cycle");
	a_ack_caused: assert property (ack |-> $past(req))
		else $error("answer without a request");
	a_req_held: assert property (s_take |=> req)
		else $error("request dropped before its answer");
	a_load_stable: assert property (s_take |=> $stable({we, idx, wdata}))
		else $error("request payload changed before its answer");
	a_req_drops: assert property (ack |-> s_close)
		else $error("request not released after the answer");
	a_gap_two: assert property ($fell(req) |-> !req ##1 !req)
		else $error("requests closer than two idle cycles");
	a_addr_pair: assert property (req && !ack && hi_seen_r |-> we && idx == osdp_pkg::REG_ADDR_LO)
		else $error("high address bit not followed by the low address byte");
	a_rdata_hold: assert property ($changed(rdata) |-> ack)
		else $error("read data changed outside an answer");
endmodule : osdp_port_props

/* File: osdp_bench.sv */
// Self-checking bench: controller and display device joined over the register port.
`timescale 1ns/1ps
module osdp_bench;
	localparam logic [2:0] K_WR = 3'b000;
	localparam logic [2:0] K_RD = 3'b001;
	localparam logic [2:0] K_AD = 3'b010;
	localparam logic [2:0] K_ST = 3'b101;
	logic        aclk;
	logic        aresetn;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, sd;
	logic [1:0]  bresp, rresp, rr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        vsync_n, hsync_n, row_last_line, in_plane_one, in_plane_two, char_luma;
	logic [8:0]  disp_addr;
	logic [15:0] disp_word;
	logic [2:0]  colour_index;
	logic        raster_active, plane_active, luma_blank_output, shared_port_pin, irq;
	logic [3:0]  display_line_count;
	logic [7:0]  b;
	int          fails = 0;
	int          num_checks = 0;
	int          irq_cnt = 0;
	int          n0 = 0;
	osdp_if link ();
	osdp_cpu u_osdp_cpu (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .port(link));
	osdp_device u_osdp_device (.aclk(aclk), .aresetn(aresetn), .bus(link),
		.vsync_n(vsync_n), .hsync_n(hsync_n), .row_last_line(row_last_line),
		.in_plane_one(in_plane_one), .in_plane_two(in_plane_two), .char_luma(char_luma),
		.disp_addr(disp_addr), .disp_word(disp_word), .colour_index(colour_index),
		.raster_active(raster_active), .plane_active(plane_active),
		.luma_blank_output(luma_blank_output), .shared_port_pin(shared_port_pin),
		.display_line_count(display_line_count), .irq(irq));
	osdp_port_props u_props (.aclk(aclk), .aresetn(aresetn), .req(link.req), .we(link.we),
		.idx(link.idx), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		bit da = 0;
		bit dw = 0;
		bit db = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!db) begin
			@(posedge aclk);
			if (!da && awready === 1'b1) begin
				da = 1;
				awvalid <= 1'b0;
			end
			if (!dw && wready === 1'b1) begin
				dw = 1;
				wvalid <= 1'b0;
			end
			if (bvalid === 1'b1) begin
				db = 1;
				r = bresp;
				bready <= 1'b0;
			end
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		bit da = 0;
		bit dr = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!dr) begin
			@(posedge aclk);
			if (!da && arready === 1'b1) begin
				da = 1;
				arvalid <= 1'b0;
			end
			if (rvalid === 1'b1) begin
				dr = 1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
	endtask : axi_rd
	// Issues one command and polls until the controller is idle again.
	task automatic op(input logic [2:0] k, input logic [3:0] i, input logic [8:0] v);
		logic [1:0]  r;
		logic [31:0] s;
		int          n;
		axi_wr(osdp_pkg::HOST_CMD, {16'h0000, k, i, v}, r);
		n = 0;
		s = 32'h00000001;
		while (s[0] !== 1'b0 && n < 200) begin
			axi_rd(osdp_pkg::HOST_STATUS, s, r);
			n++;
		end
		chk("idle", {15'h0000, s[0]}, 16'h0000);
		b = s[15:8];
	endtask : op
	task automatic rdc(input string n, input logic [3:0] i, input logic [7:0] e);
		op(K_RD, i, 9'h000);
		chk(n, {8'h00, b}, {8'h00, e});
	endtask : rdc
	task automatic pl(input logic p1, input logic p2, input logic [4:0] e);
		in_plane_one <= p1;
		in_plane_two <= p2;
		repeat (3) @(posedge aclk);
		chk("plane", {11'h000, colour_index, plane_active, shared_port_pin}, {11'h000, e});
	endtask : pl
	task automatic mw(input logic [8:0] a, input logic [15:0] m, input logic [15:0] e);
		disp_addr <= a;
		repeat (3) @(posedge aclk);
		chk("word", disp_word & m, e);
		@(posedge aclk);
		disp_addr <= 9'h1ff;
	endtask : mw
	task automatic vs;
		vsync_n <= 1'b0;
		repeat (6) @(posedge aclk);
		vsync_n <= 1'b1;
		repeat (6) @(posedge aclk);
	endtask : vs
	task automatic hs(input logic last);
		row_last_line <= last;
		hsync_n <= 1'b0;
		repeat (6) @(posedge aclk);
		hsync_n <= 1'b1;
		repeat (6) @(posedge aclk);
	endtask : hs
	task automatic chkl(input logic [3:0] c, input int n);
		chk("lines", {12'h000, display_line_count}, {12'h000, c});
		chk("irqs", 16'(irq_cnt - n0), 16'(n));
	endtask : chkl
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// Free-running clock, 8 ns period.
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// Counts interrupt pulses.
	always @(posedge aclk) begin
		if (irq === 1'b1) irq_cnt++;
	end
	// Cuts a hang short.
	initial begin
		repeat (40000) @(posedge aclk);
		fails++;
		report_and_stop();
	end
	// Main sequence of tests.
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'b000000;
		{awaddr, araddr, wdata, disp_addr} = '0;
		wstrb = 4'hf;
		{vsync_n, hsync_n, row_last_line, in_plane_one, in_plane_two, char_luma} = 6'b110000;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		for (int i = 0; i < 4; i++) rdc("reset", 4'(i), 8'h00);
		$display("test reset done");
		op(K_WR, osdp_pkg::REG_PINF, 9'h004);
		op(K_WR, osdp_pkg::REG_AREA, 9'h02d);
		op(K_WR, osdp_pkg::REG_RASTER, 9'h073);
		rdc("area", osdp_pkg::REG_AREA, 8'h2d);
		pl(1'b0, 1'b0, 5'b01100);
		chk("raster", {15'h0000, raster_active}, 16'h0001);
		chk("luma", {15'h0000, luma_blank_output}, 16'h0001);
		pl(1'b1, 1'b0, 5'b10111);
		pl(1'b0, 1'b1, 5'b01010);
		pl(1'b1, 1'b1, 5'b10111);
		op(K_WR, osdp_pkg::REG_RASTER, 9'h063);
		pl(1'b1, 1'b1, 5'b01010);
		pl(1'b1, 1'b0, 5'b01100);
		op(K_WR, osdp_pkg::REG_AREA, 9'h0ad);
		pl(1'b0, 1'b1, 5'b01011);
		for (int k = 0; k < 8; k++) begin
			op(K_WR, osdp_pkg::REG_RASTER, 9'h040 | 9'(k));
			pl(1'b0, 1'b0, {3'(k), 2'b00});
		end
		// Intensity pin disabled, blank select off, raster blanking off.
		op(K_WR, osdp_pkg::REG_PINF, 9'h008);
		op(K_WR, osdp_pkg::REG_RASTER, 9'h023);
		pl(1'b0, 1'b1, 5'b01010);
		chk("raster", {15'h0000, raster_active}, 16'h0000);
		chk("luma", {15'h0000, luma_blank_output}, 16'h0000);
		$display("test planes done");
		op(K_WR, osdp_pkg::REG_MISC, 9'h000);
		op(K_AD, 4'h0, 9'h120);
		op(K_WR, osdp_pkg::REG_CODE_HI, 9'h001);
		op(K_WR, osdp_pkg::REG_CODE_LO, 9'h020);
		op(K_WR, osdp_pkg::REG_ORN, 9'h005);
		mw(9'h120, 16'h01ff, 16'h0120);
		mw(9'h121, 16'hfe00, 16'h0a00);
		op(K_WR, osdp_pkg::REG_MISC, 9'h002);
		op(K_AD, 4'h0, 9'h010);
		op(K_WR, osdp_pkg::REG_ORN, 9'h03a);
		op(K_WR, osdp_pkg::REG_CODE_HI, 9'h000);
		op(K_WR, osdp_pkg::REG_CODE_LO, 9'h055);
		op(K_WR, osdp_pkg::REG_CODE_LO, 9'h066);
		mw(9'h010, 16'hffff, 16'h7455);
		mw(9'h011, 16'h01ff, 16'h0066);
		op(K_WR, osdp_pkg::REG_MISC, 9'h001);
		op(K_AD, 4'h0, 9'h120);
		rdc("code_hi", osdp_pkg::REG_CODE_HI, 8'h01);
		rdc("code_lo", osdp_pkg::REG_CODE_LO, 8'h20);
		rdc("orn", osdp_pkg::REG_ORN, 8'h05);
		op(K_WR, osdp_pkg::REG_MISC, 9'h003);
		op(K_AD, 4'h0, 9'h010);
		rdc("orn", osdp_pkg::REG_ORN, 8'h3a);
		rdc("code_hi", osdp_pkg::REG_CODE_HI, 8'h00);
		rdc("code_lo", osdp_pkg::REG_CODE_LO, 8'h55);
		rdc("code_lo", osdp_pkg::REG_CODE_LO, 8'h66);
		op(K_WR, osdp_pkg::REG_MISC, 9'h005);
		op(K_AD, 4'h0, 9'h011);
		rdc("code_lo", osdp_pkg::REG_CODE_LO, 8'h66);
		rdc("code_lo", osdp_pkg::REG_CODE_LO, 8'h66);
		op(K_WR, osdp_pkg::REG_MISC, 9'h004);
		op(K_WR, osdp_pkg::REG_CODE_HI, 9'h001);
		op(K_WR, osdp_pkg::REG_CODE_LO, 9'h077);
		op(K_WR, osdp_pkg::REG_CODE_LO, 9'h078);
		mw(9'h011, 16'h01ff, 16'h0177);
		mw(9'h012, 16'h01ff, 16'h0178);
		rdc("unmapped", 4'hf, 8'h00);
		axi_rd(4'h8, sd, rr);
		chk("rresp", {14'h0000, rr}, {14'h0000, osdp_pkg::RESP_SLVERR});
		axi_wr(4'h8, 32'h00000000, rr);
		chk("bresp", {14'h0000, rr}, {14'h0000, osdp_pkg::RESP_SLVERR});
		// A command without both low byte lanes is answered but ignored.
		wstrb <= 4'hc;
		axi_wr(osdp_pkg::HOST_CMD, 32'h0000_0011, rr);
		wstrb <= 4'hf;
		chk("bresp", {14'h0000, rr}, {14'h0000, osdp_pkg::RESP_OKAY});
		axi_rd(osdp_pkg::HOST_CMD, sd, rr);
		chk("cmd", sd[15:0], {K_RD, 4'hf, 9'h000});
		$display("test memory done");
		op(K_WR, osdp_pkg::REG_IRQ, 9'h002);
		n0 = irq_cnt;
		vs();
		chkl(4'h0, 0);
		hs(1'b1);
		chkl(4'h1, 0);
		hs(1'b0);
		chkl(4'h1, 0);
		hs(1'b1);
		chkl(4'h2, 1);
		hs(1'b1);
		chkl(4'h3, 1);
		op(K_ST, osdp_pkg::REG_IRQ, 9'h000);
		chk("irq reg", {8'h00, b}, 16'h0003);
		repeat (12) hs(1'b1);
		chkl(4'hf, 1);
		op(K_WR, osdp_pkg::REG_IRQ, 9'h010);
		vs();
		chkl(4'h0, 2);
		rdc("irq reg", osdp_pkg::REG_IRQ, 8'h10);
		op(K_WR, osdp_pkg::REG_IRQ, 9'h000);
		hs(1'b1);
		chkl(4'h1, 2);
		vs();
		chkl(4'h0, 3);
		$display("test lines done");
		report_and_stop();
	end
endmodule : osdp_bench
